// ===== hw/sss_pkg.sv
// Package of constants for the safe stop sequencer.
package sss_pkg;
    localparam logic [5:0]  ADR_CTRL        = 6'h00;
    localparam logic [5:0]  ADR_SELECT      = 6'h04;
    localparam logic [5:0]  ADR_STOP_DELAY  = 6'h08;
    localparam logic [5:0]  ADR_DISC_TIME   = 6'h0C;
    localparam logic [5:0]  ADR_TRANS_TIME  = 6'h10;
    localparam logic [5:0]  ADR_ENABLE      = 6'h14;
    localparam logic [5:0]  ADR_MSG_CFG     = 6'h18;
    localparam logic [5:0]  ADR_STATUS      = 6'h1C;
    localparam logic [5:0]  ADR_BRAKE_TYPE  = 6'h20;
    localparam logic [7:0]  ENA_TERMINALS   = 8'h01;
    localparam logic [7:0]  ENA_FIELDBUS    = 8'h08;
    localparam logic [7:0]  ENA_BOTH        = 8'h09;
    localparam int          ENA_EXT_BIT     = 6;
    localparam logic [15:0] RST_DELAY       = 16'h0000;
    localparam logic [15:0] RST_DISC        = 16'h0001;
    localparam logic [15:0] RST_TRANS       = 16'h0001;
    localparam logic [7:0]  RST_ENABLE      = 8'h00;
    localparam logic [1:0]  MSG_NONE        = 2'h0;
    localparam logic [1:0]  MSG_ALARM       = 2'h1;
    localparam logic [1:0]  MSG_FAULT       = 2'h2;
    localparam real         MCLK_NS         = 25.0;
    localparam real         CYCLE_US        = 4000.0;
    localparam int          CYCLE_CLKS      = int'(CYCLE_US * 1000.0 / MCLK_NS);
endpackage

// ===== hw/sss_channel.sv
// One monitoring channel: safe stop delay timer and torque disconnect state.
`timescale 1ns/10ps
`default_nettype none
module sss_channel (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire logic        sel_torque_off,
    input  wire logic        sel_stop,
    input  wire logic [15:0] stop_delay,
    output logic             stop_running,
    output logic             expired,
    output logic             torque_off
);
    logic [15:0] count;
    logic        done;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count        <= 16'h0000;
            stop_running <= 1'b0;
            expired      <= 1'b0;
            done         <= 1'b0;
        end else if (tick) begin
            expired <= 1'b0;
            if (!stop_running && !done && sel_stop) begin
                stop_running <= 1'b1;
                count        <= stop_delay;
            end else if (stop_running) begin
                if (count <= 16'h0001) begin
                    stop_running <= 1'b0;
                    expired      <= 1'b1;
                    done         <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end else if (!sel_stop) begin
                done <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            torque_off <= 1'b1;
        end else if (tick) begin
            torque_off <= sel_torque_off | expired | done;
        end
    end
endmodule
`default_nettype wire

// ===== hw/sss_top.sv
// Safe stop sequencer top level with Wishbone register slave.
//
// Overview of operation
// - One-channel select/deselect within discrepancy time suppresses pulses, message only if configured.
// - Torque disconnect beats armature short-circuit and cancels an active one.
// - Timed safe stop ramps via quick stop, then torque disconnect after delay.
// - Delay above zero: terminals select only timed stop; fieldbus selects either.
// - Delay zero: every source selects only torque disconnect.
// - Delay timer runs to expiry; then disconnect and brake hold until deselection.
// - One-channel selection coasts after discrepancy plus transition if delay not shorter.
// - Delay timer is duplicated per channel; ramp runs on one channel.
// - Timed safe stop forces setpoint limit zero in all three indices.
// - External stop starts delay without ramp and reports selection.
// - External stop brakes nothing itself; only disconnect and brake at expiry.
// - Status words and configurable messages report disconnect and timed stop.
// - Timed stop available only with enable value 1, 8, 9 or extension bit.
// - Brake driven open and closed through two channels.
// - Detected safe brake relay defaults brake type setting to zero.
// - Selection suppresses pulses per channel and closes brake; deselect releases.
// - Brake control acts only together with torque disconnect.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module sss_top #(
    parameter int CYCLE_CLKS = sss_pkg::CYCLE_CLKS
) (
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [1:0]  TERM_SEL_N,
    input  wire logic        BRAKE_RELAY_PRESENT,
    output logic      [1:0]  PULSE_SUPPRESS,
    output logic      [1:0]  BRAKE_CLOSE,
    output logic             QUICK_STOP,
    output logic             SETPOINT_LIMIT_ZERO,
    output logic             STOP_INFO,
    output logic             ARMATURE_SHORT,
    output logic             MSG_TORQUE_OFF,
    output logic             MSG_SAFE_STOP
);
    if (CYCLE_CLKS < 2) begin : g_bad_cycle
        $error("CYCLE_CLKS must be at least 2.");
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]  term_meta;
    logic [1:0]  term_sync;
    logic [1:0]  relay_sync;
    logic [31:0] tick_cnt;
    logic        tick;
    logic [7:0]  enable;
    logic [15:0] stop_delay;
    logic [15:0] disc_time;
    logic [15:0] trans_time;
    logic        ext_stop_sel;
    logic        arm_short_req;
    logic [1:0]  fb_sel_torque_off;
    logic [1:0]  fb_sel_stop;
    logic [1:0]  msg_cfg_torque;
    logic [1:0]  msg_cfg_stop;
    logic        brake_type;
    logic        relay_seen;
    logic [1:0]  disc_events;
    logic [15:0] disc_cnt;
    logic        disc_active;
    logic        coast;
    logic [1:0]  ch_running;
    logic [1:0]  ch_expired;
    logic [1:0]  ch_torque_off;
    logic [1:0]  sel_to;
    logic [1:0]  sel_ss;
    logic        stop_avail;
    logic [16:0] coast_limit;
    logic [15:0] status;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            term_meta  <= 2'h0;
            term_sync  <= 2'h0;
            relay_sync <= 2'h0;
        end else begin
            term_meta  <= ~TERM_SEL_N;
            term_sync  <= term_meta;
            relay_sync <= {relay_sync[0], BRAKE_RELAY_PRESENT};
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b0;
        end else if (tick_cnt >= 32'(CYCLE_CLKS - 1)) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
            tick     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic avail(input logic [7:0] ena);
        avail = (ena == sss_pkg::ENA_TERMINALS) || (ena == sss_pkg::ENA_FIELDBUS)
              || (ena == sss_pkg::ENA_BOTH) || ena[sss_pkg::ENA_EXT_BIT];
    endfunction

    assign stop_avail = avail(enable) && (stop_delay != 16'h0000);
    assign coast_limit = {1'b0, disc_time} + {1'b0, trans_time};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_ch
            // Terminals select only timed stop when it is enabled.
            assign sel_ss[i] = stop_avail & (term_sync[i] | fb_sel_stop[i]);
            assign sel_to[i] = (~stop_avail & (term_sync[i] | fb_sel_stop[i]))
                             | fb_sel_torque_off[i];
            sss_channel u_ch (
                .clk            (MCLK),
                .rst_n          (RESETN),
                .tick           (tick),
                .sel_torque_off (sel_to[i] | (coast & ~ch_expired[i])),
                .sel_stop       (sel_ss[i]),
                .stop_delay     (stop_delay),
                .stop_running   (ch_running[i]),
                .expired        (ch_expired[i]),
                .torque_off     (ch_torque_off[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    assign disc_events = sel_to | sel_ss;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            disc_cnt    <= 16'h0;
            disc_active <= 1'b0;
            coast       <= 1'b0;
        end else if (tick) begin
            if (disc_events[0] ^ disc_events[1]) begin
                disc_active <= 1'b1;
                if (!coast) begin
                    disc_cnt <= disc_cnt + 16'h1;
                end
                if (stop_avail && ({1'b0, stop_delay} >= coast_limit)
                    && ({1'b0, disc_cnt} >= coast_limit)) begin
                    coast <= 1'b1;
                end
            end else begin
                disc_active <= 1'b0;
                disc_cnt    <= 16'h0;
                coast       <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            PULSE_SUPPRESS      <= 2'h3;
            BRAKE_CLOSE         <= 2'h3;
            QUICK_STOP          <= 1'b0;
            SETPOINT_LIMIT_ZERO <= 1'b1;
            STOP_INFO           <= 1'b0;
            ARMATURE_SHORT      <= 1'b0;
        end else begin
            PULSE_SUPPRESS <= ch_torque_off;
            BRAKE_CLOSE    <= ch_torque_off;
            QUICK_STOP     <= (|ch_running) & ~ext_stop_sel & ~coast;
            SETPOINT_LIMIT_ZERO <= (|ch_torque_off)
                                 | ((|ch_running) & ~ext_stop_sel);
            STOP_INFO      <= (|ch_running) & ext_stop_sel;
            ARMATURE_SHORT <= arm_short_req & ~(|ch_torque_off) & ~(|sel_to);
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            MSG_TORQUE_OFF <= 1'b0;
            MSG_SAFE_STOP  <= 1'b0;
        end else begin
            MSG_TORQUE_OFF <= (msg_cfg_torque != sss_pkg::MSG_NONE)
                            & ((|ch_torque_off) | disc_active);
            MSG_SAFE_STOP  <= (msg_cfg_stop != sss_pkg::MSG_NONE) & (|ch_running);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign status = {8'h0, coast, disc_active, STOP_INFO, QUICK_STOP,
                     ch_running, ch_torque_off};

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            relay_seen <= 1'b0;
            brake_type <= 1'b1;
        end else if (relay_sync[1] && !relay_seen) begin
            relay_seen <= 1'b1;
            brake_type <= 1'b0;
        end else if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]
                     && WB_ADR_I == {2'h0, sss_pkg::ADR_BRAKE_TYPE}) begin
            brake_type <= WB_DAT_I[0];
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            WB_ACK_O          <= 1'b0;
            WB_DAT_O          <= 32'h0;
            enable            <= sss_pkg::RST_ENABLE;
            stop_delay        <= sss_pkg::RST_DELAY;
            disc_time         <= sss_pkg::RST_DISC;
            trans_time        <= sss_pkg::RST_TRANS;
            ext_stop_sel      <= 1'b0;
            arm_short_req     <= 1'b0;
            fb_sel_torque_off <= 2'h0;
            fb_sel_stop       <= 2'h0;
            msg_cfg_torque    <= sss_pkg::MSG_NONE;
            msg_cfg_stop      <= sss_pkg::MSG_NONE;
        end else begin
            WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
            WB_DAT_O <= 32'h0;
            if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
                if (WB_ADR_I[7:6] != 2'h0) begin
                    WB_DAT_O <= 32'h0;
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_CTRL) begin
                    WB_DAT_O <= {30'h0, arm_short_req, ext_stop_sel};
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        ext_stop_sel  <= WB_DAT_I[0];
                        arm_short_req <= WB_DAT_I[1];
                    end
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_SELECT) begin
                    WB_DAT_O <= {28'h0, fb_sel_stop, fb_sel_torque_off};
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        fb_sel_torque_off <= WB_DAT_I[1:0];
                        fb_sel_stop       <= WB_DAT_I[3:2];
                    end
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_STOP_DELAY) begin
                    WB_DAT_O <= {16'h0, stop_delay};
                    if (WB_WE_I && WB_SEL_I[0]) stop_delay[7:0] <= WB_DAT_I[7:0];
                    if (WB_WE_I && WB_SEL_I[1]) stop_delay[15:8] <= WB_DAT_I[15:8];
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_DISC_TIME) begin
                    WB_DAT_O <= {16'h0, disc_time};
                    if (WB_WE_I && WB_SEL_I[0]) disc_time[7:0] <= WB_DAT_I[7:0];
                    if (WB_WE_I && WB_SEL_I[1]) disc_time[15:8] <= WB_DAT_I[15:8];
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_TRANS_TIME) begin
                    WB_DAT_O <= {16'h0, trans_time};
                    if (WB_WE_I && WB_SEL_I[0]) trans_time[7:0] <= WB_DAT_I[7:0];
                    if (WB_WE_I && WB_SEL_I[1]) trans_time[15:8] <= WB_DAT_I[15:8];
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_ENABLE) begin
                    WB_DAT_O <= {24'h0, enable};
                    if (WB_WE_I && WB_SEL_I[0]) enable <= WB_DAT_I[7:0];
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_MSG_CFG) begin
                    WB_DAT_O <= {28'h0, msg_cfg_stop, msg_cfg_torque};
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        msg_cfg_torque <= WB_DAT_I[1:0];
                        msg_cfg_stop   <= WB_DAT_I[3:2];
                    end
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_STATUS) begin
                    WB_DAT_O <= {16'h0, status};
                end else if (WB_ADR_I[5:0] == sss_pkg::ADR_BRAKE_TYPE) begin
                    WB_DAT_O <= {30'h0, relay_seen, brake_type};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/sss_term_model.sv
// Terminal-side partner model driving the active-low channel selection lines.
`timescale 1ns/10ps
`default_nettype none
module sss_term_model (
    input  wire logic       clk,
    input  wire logic [1:0] sel,
    output logic      [1:0] term_sel_n
);
    // Levels change just after a clock edge; either channel may be selected alone.
    initial term_sel_n = 2'b11;
    always @(posedge clk) begin
        term_sel_n <= ~sel;
    end
endmodule
`default_nettype wire

// ===== verification/sss_top_props.sv
// Checker of port-level relations of the safe stop sequencer.
`timescale 1ns/10ps
`default_nettype none
module sss_top_props #(
    parameter int CYCLE_CLKS = sss_pkg::CYCLE_CLKS
) (
    input wire logic        MCLK,
    input wire logic        RESETN,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic [1:0]  TERM_SEL_N,
    input wire logic        BRAKE_RELAY_PRESENT,
    input wire logic [1:0]  PULSE_SUPPRESS,
    input wire logic [1:0]  BRAKE_CLOSE,
    input wire logic        QUICK_STOP,
    input wire logic        SETPOINT_LIMIT_ZERO,
    input wire logic        STOP_INFO,
    input wire logic        ARMATURE_SHORT,
    input wire logic        MSG_TORQUE_OFF,
    input wire logic        MSG_SAFE_STOP
);
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_bus_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_off_held;
        (PULSE_SUPPRESS != 2'h0) [*2];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_follows: assert property (s_bus_req |=> WB_ACK_O)
        else $error("bus request not acknowledged after one cycle");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge held longer than one cycle");
    a_data_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside acknowledge");
    a_brake_with_off: assert property ((BRAKE_CLOSE & ~PULSE_SUPPRESS) == 2'h0)
        else $error("brake closed on a channel without pulse suppression");
    a_limit_on_ramp: assert property (QUICK_STOP |-> SETPOINT_LIMIT_ZERO)
        else $error("quick stop active without setpoint limit zero");
    a_ext_no_ramp: assert property (STOP_INFO |-> !QUICK_STOP)
        else $error("quick stop ramp during external stop");
    a_short_yields: assert property (s_off_held |-> !ARMATURE_SHORT)
        else $error("armature short held while torque is disconnected");
    // Pulse suppression moves only on monitoring ticks, four clocks apart in simulation.
    a_tick_paced: assert property ($changed(PULSE_SUPPRESS) |=> $stable(PULSE_SUPPRESS) [*3])
        else $error("pulse suppression changed between monitoring ticks");
endmodule
bind sss_top sss_top_props #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (
    .MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TERM_SEL_N(TERM_SEL_N),
    .BRAKE_RELAY_PRESENT(BRAKE_RELAY_PRESENT), .PULSE_SUPPRESS(PULSE_SUPPRESS),
    .BRAKE_CLOSE(BRAKE_CLOSE), .QUICK_STOP(QUICK_STOP),
    .SETPOINT_LIMIT_ZERO(SETPOINT_LIMIT_ZERO), .STOP_INFO(STOP_INFO),
    .ARMATURE_SHORT(ARMATURE_SHORT), .MSG_TORQUE_OFF(MSG_TORQUE_OFF),
    .MSG_SAFE_STOP(MSG_SAFE_STOP));
`default_nettype wire

// ===== verification/sss_top_tb_top.sv
// Self-checking testbench for the safe stop sequencer.
`timescale 1ns/10ps
`default_nettype none
module sss_top_tb_top;
    localparam int TICK = 4;
    logic        mclk = 1'b0;
    logic        resetn, cyc, stb, we, relay, ack, qstop, lim0, sinfo, ashort, msg_to, msg_ss;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat;
    logic [1:0]  tsel, term_sel_n, pulse, brake;
    logic [3:0]  sel;
    int          num_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    always #12.5 mclk = ~mclk;
    sss_top #(.CYCLE_CLKS(TICK)) DUT (.MCLK(mclk), .RESETN(resetn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .TERM_SEL_N(term_sel_n), .BRAKE_RELAY_PRESENT(relay),
        .PULSE_SUPPRESS(pulse), .BRAKE_CLOSE(brake), .QUICK_STOP(qstop),
        .SETPOINT_LIMIT_ZERO(lim0), .STOP_INFO(sinfo), .ARMATURE_SHORT(ashort),
        .MSG_TORQUE_OFF(msg_to), .MSG_SAFE_STOP(msg_ss));
    sss_term_model u_term (.clk(mclk), .sel(tsel), .term_sel_n(term_sel_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h3;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, {2'h0, a}, d, q);
    endtask
    task automatic ticks(input int t);
        repeat (t * TICK) @(posedge mclk);
    endtask
    task automatic watch(input int t, output logic [2:0] seen);
        seen = 3'h0;
        repeat (t * TICK) begin
            @(posedge mclk);
            seen = seen | {msg_to, pulse};
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, {2'h0, sss_pkg::ADR_ENABLE}, 32'h0, q);
        check("enable_reset", {24'h0, sss_pkg::RST_ENABLE}, q);
        wb(1'b0, {2'h0, sss_pkg::ADR_BRAKE_TYPE}, 32'h0, q);
        check("brake_type_reset", 32'h1, q);
        wb(1'b1, 8'hE4, 32'h3, q);
        wb(1'b0, 8'hE4, 32'h0, q);
        check("unmapped_read", 32'h0, q);
        wb(1'b0, {2'h0, sss_pkg::ADR_SELECT}, 32'h0, q);
        check("unmapped_ignored", 32'h0, q);
        $display("t_regs done");
    endtask
    task automatic t_sto();
        logic [31:0] q;
        wr(sss_pkg::ADR_ENABLE, 32'h8);
        wr(sss_pkg::ADR_SELECT, 32'h3);
        ticks(4);
        check("sto_pulse", 32'h3, {30'h0, pulse});
        check("sto_brake", 32'h3, {30'h0, brake});
        wb(1'b0, {2'h0, sss_pkg::ADR_STATUS}, 32'h0, q);
        check("sto_status", 32'h3, {30'h0, q[1:0]});
        wr(sss_pkg::ADR_SELECT, 32'h0);
        ticks(4);
        check("sto_release", 32'h0, {30'h0, pulse});
        $display("t_sto done");
    endtask
    task automatic t_ss1();
        logic [2:0] seen;
        wr(sss_pkg::ADR_ENABLE, 32'h1);
        wr(sss_pkg::ADR_STOP_DELAY, 32'h6);
        tsel <= 2'b11;
        ticks(3);
        check("ss1_ramp", 32'h1, {31'h0, qstop});
        check("ss1_limit", 32'h1, {31'h0, lim0});
        check("ss1_no_message", 32'h0, {31'h0, msg_ss});
        check("ss1_no_direct", 32'h0, {30'h0, pulse});
        tsel <= 2'b00;
        watch(10, seen);
        check("ss1_expiry_pulse", 32'h3, {30'h0, seen[1:0]});
        check("ss1_released", 32'h0, {30'h0, pulse});
        $display("t_ss1 done");
    endtask
    task automatic t_enable();
        logic [7:0] codes [4] = '{8'h01, 8'h08, 8'h09, 8'h40};
        foreach (codes[i]) begin
            wr(sss_pkg::ADR_ENABLE, {24'h0, codes[i]});
            wr(sss_pkg::ADR_SELECT, 32'hC);
            tsel <= 2'b11;
            ticks(3);
            check("enable_ramp", 32'h1, {31'h0, qstop});
            wr(sss_pkg::ADR_SELECT, 32'h0);
            tsel <= 2'b00;
            ticks(10);
        end
        $display("t_enable done");
    endtask
    task automatic t_direct();
        logic [31:0] cfg [2] = '{32'h1_0000, 32'h2_0006};
        foreach (cfg[i]) begin
            wr(sss_pkg::ADR_ENABLE, {24'h0, cfg[i][23:16]});
            wr(sss_pkg::ADR_STOP_DELAY, {16'h0, cfg[i][15:0]});
            tsel <= 2'b11;
            ticks(4);
            check("direct_pulse", 32'h3, {30'h0, pulse});
            check("direct_no_ramp", 32'h0, {31'h0, qstop});
            tsel <= 2'b00;
            ticks(4);
        end
        $display("t_direct done");
    endtask
    task automatic t_ext();
        wr(sss_pkg::ADR_CTRL, 32'h1);
        wr(sss_pkg::ADR_MSG_CFG, 32'h4);
        wr(sss_pkg::ADR_ENABLE, 32'h8);
        wr(sss_pkg::ADR_STOP_DELAY, 32'h6);
        wr(sss_pkg::ADR_SELECT, 32'hC);
        ticks(3);
        check("ext_info", 32'h1, {31'h0, sinfo});
        check("ext_message", 32'h1, {31'h0, msg_ss});
        check("ext_no_ramp", 32'h0, {31'h0, qstop});
        check("ext_running", 32'h0, {30'h0, pulse});
        ticks(7);
        check("ext_expiry_off", 32'h3, {30'h0, pulse});
        check("ext_expiry_brake", 32'h3, {30'h0, brake});
        wr(sss_pkg::ADR_SELECT, 32'h0);
        wr(sss_pkg::ADR_CTRL, 32'h0);
        ticks(4);
        $display("t_ext done");
    endtask
    task automatic t_arm();
        wr(sss_pkg::ADR_CTRL, 32'h2);
        ticks(3);
        check("arm_on", 32'h1, {31'h0, ashort});
        wr(sss_pkg::ADR_SELECT, 32'h3);
        ticks(4);
        check("arm_cancelled", 32'h0, {31'h0, ashort});
        wr(sss_pkg::ADR_SELECT, 32'h0);
        wr(sss_pkg::ADR_CTRL, 32'h0);
        ticks(4);
        $display("t_arm done");
    endtask
    task automatic t_disc();
        logic [2:0] seen;
        wr(sss_pkg::ADR_ENABLE, 32'h1);
        wr(sss_pkg::ADR_STOP_DELAY, 32'h0);
        wr(sss_pkg::ADR_DISC_TIME, 32'h8);
        for (int c = 0; c < 2; c++) begin
            wr(sss_pkg::ADR_MSG_CFG, c);
            tsel <= 2'b01;
            ticks(2);
            tsel <= 2'b00;
            watch(6, seen);
            check("disc_pulse", 32'h1, {31'h0, seen[0]});
            check("disc_message", c, {31'h0, seen[2]});
            ticks(4);
        end
        $display("t_disc done");
    endtask
    task automatic t_coast();
        wr(sss_pkg::ADR_STOP_DELAY, 32'h6);
        wr(sss_pkg::ADR_DISC_TIME, 32'h2);
        tsel <= 2'b01;
        ticks(8);
        check("coast_pulse", 32'h3, {30'h0, pulse});
        check("coast_no_ramp", 32'h0, {31'h0, qstop});
        tsel <= 2'b00;
        ticks(10);
        check("coast_released", 32'h0, {30'h0, pulse});
        $display("t_coast done");
    endtask
    task automatic t_relay();
        logic [31:0] q;
        relay <= 1'b1;
        ticks(2);
        wb(1'b0, {2'h0, sss_pkg::ADR_BRAKE_TYPE}, 32'h0, q);
        check("relay_brake_type", 32'h2, q);
        $display("t_relay done");
    endtask
    initial begin
        resetn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'h0;
        adr = 8'h0;
        wdat = 32'h0;
        tsel = 2'b00;
        relay = 1'b0;
        repeat (2) @(posedge mclk);
        check("reset_pulse", 32'h3, {30'h0, pulse});
        resetn <= 1'b1;
        ticks(3);
        t_regs();
        t_sto();
        t_ss1();
        t_enable();
        t_direct();
        t_ext();
        t_arm();
        t_disc();
        t_coast();
        t_relay();
        complete_run();
    end
endmodule
`default_nettype wire
